// ==== rtl/posc_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - at the end of reset the strap lines are latched into registers.
// - host clock pad strap shows in 4C bit 2, low external, high internal.
// - memory clock pad strap shows in 4C bit 3, zero external.
// - dot clock pad strap shows in 4C bit 4, zero external.
// - five host pll speed straps show in 5F bits 7:6 and 5:3.
// - pci divisor straps show in 4A bit 4 and 4C bit 1.
// - pci clock is host clock over 4, 3 when only a is high, 2 if both.
// - two pci range straps show in 4A bits 7:6 and set the pci pll.
// - range code 00 is 16-32, 01 is 32-64, 10 above 64, 11 reserved.
// - sync strap zero leaves memory and host clocks unsynchronised.
// - strap line 23 shows in both 5F bit 2 and 4C bit 5.
// - bus select strap acts in hardware only and is never readable.
module posc_top (
    input  wire logic                          CLOCK_I,
    input  wire logic                          SYS_RST_I,
    input  wire logic [posc_pkg::STRAP_W-1:0]  STRAP_DATA_LINE_I,
    input  wire logic                          CFG_WR_I,
    input  wire logic [7:0]                    CFG_ADDR_I,
    input  wire logic [7:0]                    CFG_WDATA_I,
    output logic      [7:0]                    CFG_RDATA_O,
    output logic                               CFG_HIT_O,
    output logic                               CFG_VALID_O,
    output logic                               HOST_CLK_INTERNAL_O,
    output logic                               MEM_CLK_INTERNAL_O,
    output logic                               DOT_CLK_INTERNAL_O,
    output logic                               MEM_HOST_SYNC_O,
    output logic      [1:0]                    PCI_RANGE_O,
    output logic      [2:0]                    PCI_CLOCK_OUTPUT_DIV_O,
    output logic      [4:0]                    HOST_PLL_SPEED_O,
    output logic                               CPU_MODE_O,
    output logic                               BUS_SELECT_LOCAL_O
);

    posc_pkg::posc_state_t  state_q;
    posc_pkg::posc_cfg_t    cfg;
    logic [posc_pkg::STRAP_W-1:0] sd;
    logic       load;
    logic [7:0] img_4a;
    logic [7:0] img_4b;
    logic [7:0] img_4c;
    logic [7:0] img_5f;
    logic [7:0] r4a;
    logic [7:0] r4b;
    logic [7:0] r4c;
    logic [7:0] r5f;
    logic       hw_cpu_q;
    logic       hw_bus_q;

    assign sd = STRAP_DATA_LINE_I;

    // capture sequencer: one sample cycle right after reset release
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q <= posc_pkg::ST_RESET;
        end else begin
            case (state_q)
                posc_pkg::ST_RESET:  state_q <= posc_pkg::ST_SAMPLE;
                posc_pkg::ST_SAMPLE: state_q <= posc_pkg::ST_RUN;
                posc_pkg::ST_RUN:    state_q <= posc_pkg::ST_RUN;
                default:             state_q <= posc_pkg::ST_RESET;
            endcase
        end
    end

    assign load = (state_q == posc_pkg::ST_RESET);

    always_comb begin
        img_4a = posc_pkg::REG_RESET;
        img_4a[posc_pkg::BIT_RANGE_LO +: 2] = sd[posc_pkg::LN_PCI_RANGE +: 2];
        img_4a[posc_pkg::BIT_MEM_SYNC] = sd[posc_pkg::LN_MEM_SYNC];
        img_4a[posc_pkg::BIT_PCI_DIV_A] = sd[posc_pkg::LN_PCI_DIV_A];
        img_4a[3:2] = sd[posc_pkg::LN_PLL_SPD_LO +: 2];
    end

    always_comb begin
        img_4b = posc_pkg::REG_RESET;
        img_4b[7:1] = {sd[posc_pkg::LN_DESKEW_LO +: 6], sd[1]};
    end

    always_comb begin
        img_4c = posc_pkg::REG_RESET;
        img_4c[0] = sd[posc_pkg::LN_CLK_PAD_LO];
        img_4c[posc_pkg::BIT_DIV_B] = sd[posc_pkg::LN_PCI_DIV_B];
        img_4c[posc_pkg::BIT_HOST_PAD] = sd[posc_pkg::LN_HOST_PAD];
        img_4c[posc_pkg::BIT_MEM_PAD] = sd[posc_pkg::LN_MEM_PAD];
        img_4c[posc_pkg::BIT_DOT_PAD] = sd[posc_pkg::LN_DOT_PAD];
        img_4c[posc_pkg::BIT_DUAL_4C] = sd[posc_pkg::LN_DUAL];
    end

    always_comb begin
        img_5f = posc_pkg::REG_RESET;
        img_5f[7:6] = sd[posc_pkg::LN_PLL_SPD_LO +: 2];
        img_5f[5:3] = sd[posc_pkg::LN_PLL_SPD_HI +: 3];
        img_5f[2:0] = sd[posc_pkg::LN_PLL_LO +: 3];
    end

    // hold captured until reset or write
    posc_reg8 #(.INDEX(posc_pkg::IDX_CLK_STRAP_A)) u_r4a (
        .clk_i      (CLOCK_I),
        .rst_i      (SYS_RST_I),
        .load_i     (load),
        .load_val_i (img_4a),
        .wr_i       (CFG_WR_I),
        .addr_i     (CFG_ADDR_I),
        .wdata_i    (CFG_WDATA_I),
        .val_o      (r4a)
    );
    posc_reg8 #(.INDEX(posc_pkg::IDX_DESKEW_STRAP)) u_r4b (
        .clk_i      (CLOCK_I),
        .rst_i      (SYS_RST_I),
        .load_i     (load),
        .load_val_i (img_4b),
        .wr_i       (CFG_WR_I),
        .addr_i     (CFG_ADDR_I),
        .wdata_i    (CFG_WDATA_I),
        .val_o      (r4b)
    );
    posc_reg8 #(.INDEX(posc_pkg::IDX_CLK_PAD_STRAP)) u_r4c (
        .clk_i      (CLOCK_I),
        .rst_i      (SYS_RST_I),
        .load_i     (load),
        .load_val_i (img_4c),
        .wr_i       (CFG_WR_I),
        .addr_i     (CFG_ADDR_I),
        .wdata_i    (CFG_WDATA_I),
        .val_o      (r4c)
    );
    posc_reg8 #(.INDEX(posc_pkg::IDX_HOST_PLL)) u_r5f (
        .clk_i      (CLOCK_I),
        .rst_i      (SYS_RST_I),
        .load_i     (load),
        .load_val_i (img_5f),
        .wr_i       (CFG_WR_I),
        .addr_i     (CFG_ADDR_I),
        .wdata_i    (CFG_WDATA_I),
        .val_o      (r5f)
    );

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            hw_cpu_q <= 1'h0;
            hw_bus_q <= 1'h0;
        end else if (load) begin
            hw_cpu_q <= sd[posc_pkg::LN_CPU_MODE];
            hw_bus_q <= sd[posc_pkg::LN_BUS_SEL];
        end
    end

    always_comb begin
        cfg.host_clk_internal = r4c[posc_pkg::BIT_HOST_PAD];
        cfg.mem_clk_internal  = r4c[posc_pkg::BIT_MEM_PAD];
        cfg.dot_clk_internal  = r4c[posc_pkg::BIT_DOT_PAD];
        cfg.mem_host_sync     = r4a[posc_pkg::BIT_MEM_SYNC];
        cfg.pci_range = posc_pkg::posc_range_t'(
            r4a[posc_pkg::BIT_RANGE_LO +: 2]);
        if (!r4a[posc_pkg::BIT_PCI_DIV_A]) begin
            cfg.pci_div = posc_pkg::DIV_BY_4;
        end else if (!r4c[posc_pkg::BIT_DIV_B]) begin
            cfg.pci_div = posc_pkg::DIV_BY_3;
        end else begin
            cfg.pci_div = posc_pkg::DIV_BY_2;
        end
        cfg.host_pll_speed   = {r5f[7:6], r5f[5:3]};
        cfg.cpu_mode         = hw_cpu_q;
        cfg.bus_select_local = hw_bus_q;
    end

    // read mux, unmapped index reads zero
    always_comb begin
        CFG_HIT_O = 1'h1;
        case (CFG_ADDR_I)
            posc_pkg::IDX_CLK_STRAP_A:   CFG_RDATA_O = r4a;
            posc_pkg::IDX_DESKEW_STRAP:  CFG_RDATA_O = r4b;
            posc_pkg::IDX_CLK_PAD_STRAP: CFG_RDATA_O = r4c;
            posc_pkg::IDX_HOST_PLL:      CFG_RDATA_O = r5f;
            default: begin
                CFG_RDATA_O = 8'h00;
                CFG_HIT_O   = 1'h0;
            end
        endcase
    end

    assign CFG_VALID_O            = (state_q == posc_pkg::ST_RUN);
    assign HOST_CLK_INTERNAL_O    = cfg.host_clk_internal;
    assign MEM_CLK_INTERNAL_O     = cfg.mem_clk_internal;
    assign DOT_CLK_INTERNAL_O     = cfg.dot_clk_internal;
    assign MEM_HOST_SYNC_O        = cfg.mem_host_sync;
    assign PCI_RANGE_O            = cfg.pci_range;
    assign PCI_CLOCK_OUTPUT_DIV_O = cfg.pci_div;
    assign HOST_PLL_SPEED_O       = cfg.host_pll_speed;
    assign CPU_MODE_O             = cfg.cpu_mode;
    assign BUS_SELECT_LOCAL_O     = cfg.bus_select_local;

endmodule

`default_nettype wire

// ==== rtl/posc_pkg.sv ====
package posc_pkg;

    // strap bus width, lines 0..48
    localparam int STRAP_W = 49;

    // configuration index offsets
    localparam logic [7:0] IDX_CLK_STRAP_A   = 8'h4A;
    localparam logic [7:0] IDX_DESKEW_STRAP  = 8'h4B;
    localparam logic [7:0] IDX_CLK_PAD_STRAP = 8'h4C;
    localparam logic [7:0] IDX_HOST_PLL      = 8'h5F;

    // strap line positions
    localparam int LN_PLL_SPD_LO  = 2;
    localparam int LN_PCI_DIV_A   = 4;
    localparam int LN_MEM_SYNC    = 5;
    localparam int LN_PCI_RANGE   = 6;
    localparam int LN_DESKEW_LO   = 10;
    localparam int LN_CLK_PAD_LO  = 16;
    localparam int LN_PCI_DIV_B   = 17;
    localparam int LN_HOST_PAD    = 18;
    localparam int LN_MEM_PAD     = 19;
    localparam int LN_DOT_PAD     = 20;
    localparam int LN_PLL_LO      = 21;
    localparam int LN_PLL_SPD_HI  = 24;
    localparam int LN_DUAL        = 23;
    localparam int LN_CPU_MODE    = 40;
    localparam int LN_BUS_SEL     = 44;

    // register bit positions
    localparam int BIT_PCI_DIV_A  = 4;
    localparam int BIT_MEM_SYNC   = 5;
    localparam int BIT_RANGE_LO   = 6;
    localparam int BIT_DIV_B      = 1;
    localparam int BIT_HOST_PAD   = 2;
    localparam int BIT_MEM_PAD    = 3;
    localparam int BIT_DOT_PAD    = 4;
    localparam int BIT_DUAL_4C    = 5;

    // register value before capture
    localparam logic [7:0] REG_RESET = 8'h00;

    // pci clock divide ratios
    localparam logic [2:0] DIV_BY_4 = 3'h4;
    localparam logic [2:0] DIV_BY_3 = 3'h3;
    localparam logic [2:0] DIV_BY_2 = 3'h2;

    typedef enum logic [1:0] {
        RANGE_16_32  = 2'h0,
        RANGE_32_64  = 2'h1,
        RANGE_ABV_64 = 2'h2,
        RANGE_RSV    = 2'h3
    } posc_range_t;

    typedef enum logic [1:0] {
        ST_RESET  = 2'h0,
        ST_SAMPLE = 2'h1,
        ST_RUN    = 2'h3
    } posc_state_t;

    typedef struct packed {
        logic        host_clk_internal;
        logic        mem_clk_internal;
        logic        dot_clk_internal;
        logic        mem_host_sync;
        posc_range_t pci_range;
        logic [2:0]  pci_div;
        logic [4:0]  host_pll_speed;
        logic        cpu_mode;
        logic        bus_select_local;
    } posc_cfg_t;

endpackage

// ==== rtl/posc_reg8.sv ====
`timescale 1ns/1ps
`default_nettype none

// one configuration index: loads strap image, then software may overwrite
module posc_reg8 #(
    parameter logic [7:0] INDEX = 8'h00
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       load_i,
    input  wire logic [7:0] load_val_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] val_o
);

    logic [7:0] val_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            val_q <= posc_pkg::REG_RESET;
        end else if (load_i) begin
            val_q <= load_val_i;
        end else if (wr_i && addr_i == INDEX) begin
            val_q <= wdata_i;
        end
    end

    assign val_o = val_q;

endmodule

`default_nettype wire

// ==== testbench/posc_top_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module posc_top_properties (
    input wire logic [posc_pkg::STRAP_W-1:0] STRAP_DATA_LINE_I,
    input wire logic                         CLOCK_I,
    input wire logic                         SYS_RST_I,
    input wire logic [7:0]                   CFG_ADDR_I,
    input wire logic [7:0]                   CFG_RDATA_O,
    input wire logic                         CFG_HIT_O,
    input wire logic                         CFG_VALID_O,
    input wire logic                         HOST_CLK_INTERNAL_O,
    input wire logic                         MEM_CLK_INTERNAL_O,
    input wire logic                         DOT_CLK_INTERNAL_O,
    input wire logic                         MEM_HOST_SYNC_O,
    input wire logic [1:0]                   PCI_RANGE_O,
    input wire logic [2:0]                   PCI_CLOCK_OUTPUT_DIV_O,
    input wire logic [4:0]                   HOST_PLL_SPEED_O,
    input wire logic                         CPU_MODE_O,
    input wire logic                         BUS_SELECT_LOCAL_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    chk_valid_timing: assert property ($fell(SYS_RST_I) |->
        !CFG_VALID_O ##1 !CFG_VALID_O ##1 CFG_VALID_O)
        else $error("valid late");
    chk_hw_capture: assert property ($rose(CFG_VALID_O) |->
        CPU_MODE_O == $past(STRAP_DATA_LINE_I[40], 2) &&
        BUS_SELECT_LOCAL_O == $past(STRAP_DATA_LINE_I[44], 2))
        else $error("hw strap not captured");
    chk_hw_hold: assert property (CFG_VALID_O |=>
        $stable({CPU_MODE_O, BUS_SELECT_LOCAL_O})) else $error("hw moved");
    chk_pad_capture: assert property ($rose(CFG_VALID_O) &&
        CFG_ADDR_I == 8'h4C |-> CFG_RDATA_O[5:0] ==
        {$past(STRAP_DATA_LINE_I[23], 2),
        $past(STRAP_DATA_LINE_I[20:16], 2)})
        else $error("4C capture wrong");
    chk_pad_dir: assert property (
        CFG_ADDR_I == 8'h4C |->
        {DOT_CLK_INTERNAL_O, MEM_CLK_INTERNAL_O, HOST_CLK_INTERNAL_O}
        == CFG_RDATA_O[4:2]) else $error("pad direction wrong");
    chk_pll_map: assert property (CFG_ADDR_I == 8'h5F |->
        HOST_PLL_SPEED_O == CFG_RDATA_O[7:3]) else $error("pll wrong");
    chk_range_map: assert property (CFG_ADDR_I == 8'h4A |->
        PCI_RANGE_O == CFG_RDATA_O[7:6] &&
        MEM_HOST_SYNC_O == CFG_RDATA_O[5]) else $error("range wrong");
    chk_div_ratio: assert property (CFG_ADDR_I == 8'h4A |->
        (CFG_RDATA_O[4] ? PCI_CLOCK_OUTPUT_DIV_O inside {3'h2, 3'h3}
        : PCI_CLOCK_OUTPUT_DIV_O == 3'h4)) else $error("divisor wrong");
    chk_div_b: assert property (CFG_ADDR_I == 8'h4C &&
        !CFG_RDATA_O[1] |-> PCI_CLOCK_OUTPUT_DIV_O != 3'h2)
        else $error("divisor b ignored");
    chk_unmapped_zero: assert property (CFG_HIT_O ==
        (CFG_ADDR_I inside {8'h4A, 8'h4B, 8'h4C, 8'h5F}) &&
        (CFG_HIT_O || CFG_RDATA_O == 8'h00)) else $error("decode wrong");
endmodule
bind posc_top posc_top_properties u_props (
    .STRAP_DATA_LINE_I(STRAP_DATA_LINE_I), .CLOCK_I(CLOCK_I),
    .SYS_RST_I(SYS_RST_I), .CFG_ADDR_I(CFG_ADDR_I),
    .CFG_RDATA_O(CFG_RDATA_O), .CFG_HIT_O(CFG_HIT_O),
    .CFG_VALID_O(CFG_VALID_O), .HOST_CLK_INTERNAL_O(HOST_CLK_INTERNAL_O),
    .MEM_CLK_INTERNAL_O(MEM_CLK_INTERNAL_O),
    .DOT_CLK_INTERNAL_O(DOT_CLK_INTERNAL_O),
    .MEM_HOST_SYNC_O(MEM_HOST_SYNC_O), .PCI_RANGE_O(PCI_RANGE_O),
    .PCI_CLOCK_OUTPUT_DIV_O(PCI_CLOCK_OUTPUT_DIV_O),
    .HOST_PLL_SPEED_O(HOST_PLL_SPEED_O), .CPU_MODE_O(CPU_MODE_O),
    .BUS_SELECT_LOCAL_O(BUS_SELECT_LOCAL_O)
);
`default_nettype wire

// ==== testbench/posc_board.sv ====
`timescale 1ns/1ps
`default_nettype none
module posc_board (
    input  wire logic [48:0] user_i,
    output logic      [48:0] strap_o
);
    localparam logic [48:0] PULL_UP = 49'h1440000E14002;
    localparam logic [48:0] PULL_DN = 49'h0AA0078000C00;
    assign strap_o = (user_i & ~(PULL_UP | PULL_DN)) | PULL_UP;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [48:0] user = '0;
    logic [48:0] cap;
    wire logic [48:0] strap;
    wire logic [7:0]  rdata;
    wire logic [4:0]  pll;
    wire logic [2:0]  div;
    wire logic [1:0]  rng;
    wire logic        hit, valid, hpad, mpad, dpad, sync, cpu, bus;
    logic [7:0]  mdl [int];
    int          mismatches = 0;
    int          comparisons = 0;
    int          k;
    initial forever #20 clk = ~clk;
    posc_board u_board (.user_i(user), .strap_o(strap));
    posc_top DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .STRAP_DATA_LINE_I(strap),
        .CFG_WR_I(wr), .CFG_ADDR_I(addr), .CFG_WDATA_I(wdata),
        .CFG_RDATA_O(rdata), .CFG_HIT_O(hit), .CFG_VALID_O(valid),
        .HOST_CLK_INTERNAL_O(hpad), .MEM_CLK_INTERNAL_O(mpad),
        .DOT_CLK_INTERNAL_O(dpad), .MEM_HOST_SYNC_O(sync),
        .PCI_RANGE_O(rng), .PCI_CLOCK_OUTPUT_DIV_O(div),
        .HOST_PLL_SPEED_O(pll), .CPU_MODE_O(cpu), .BUS_SELECT_LOCAL_O(bus));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        addr = a;
        #5;
        check(rdata, mdl.exists(a) ? mdl[a] : 8'h00);
        check({7'h00, hit}, 8'(mdl.exists(a)));
    endtask
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        if (mdl.exists(a)) mdl[a] = d;
    endtask
    task automatic outs;
        logic [2:0] d;
        d = !mdl[8'h4A][4] ? 3'h4 : (mdl[8'h4C][1] ? 3'h2 : 3'h3);
        check({5'h00, div}, {5'h00, d});
        check({2'h0, rng, sync, dpad, mpad, hpad},
            {2'h0, mdl[8'h4A][7:5], mdl[8'h4C][4:2]});
        check({3'h0, pll}, {3'h0, mdl[8'h5F][7:3]});
        check({6'h00, cpu, bus}, {6'h00, cap[40], cap[44]});
    endtask
    task automatic boot(input int n);
        @(negedge clk);
        user = 49'({$urandom, $urandom});
        rst = 1'b1;
        repeat (n) @(negedge clk);
        cap = strap;
        mdl[8'h4A] = {cap[7:2], 2'h0};
        mdl[8'h4B] = {cap[15:10], cap[1], 1'b0};
        mdl[8'h4C] = {2'h0, cap[23], cap[20:16]};
        mdl[8'h5F] = {cap[3:2], cap[26:21]};
        rst = 1'b0;
        // write in the capture cycle must be lost
        wr = 1'b1;
        addr = 8'h4C;
        wdata = ~mdl[8'h4C];
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
        check({7'h00, valid}, 8'h01);
        user = 49'({$urandom, $urandom});
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'hd2cbd87b));
        for (k = 0; k < 8; k++) begin
            boot(k == 0 ? 10 : 2);
            foreach (mdl[a]) rd(8'(a));
            outs();
            wrt(8'h4A, {k[1:0], 1'($urandom), k[2], 4'($urandom)});
            wrt(8'h4C, {6'($urandom), k[0], 1'($urandom)});
            wrt(8'h5F, 8'($urandom));
            wrt(8'h4B, 8'($urandom));
            wrt(8'h50 + 8'(k), 8'hFF);
            foreach (mdl[a]) rd(8'(a));
            rd(8'h50 + 8'(k));
            outs();
        end
        complete_run();
    end
endmodule
`default_nettype wire
